// [inc/rcs_map.svh]
`ifndef RCS_MAP_SVH
`define RCS_MAP_SVH
// command opcodes
`define RCS_OP_PKT_PARAMS 8'h8C
`define RCS_OP_CAD_CFG 8'h88
`define RCS_OP_BUF_BASE 8'h8F
`define RCS_OP_SYM_VAL 8'hA0
`define RCS_OP_STATUS 8'hC0
// legal frame lengths in bytes, opcode included
`define RCS_LEN_PKT_MIN 4'h7
`define RCS_LEN_PKT_MAX 4'hA
`define RCS_LEN_CAD 4'h8
`define RCS_LEN_BUF 4'h3
`define RCS_LEN_SYM 4'h2
`define RCS_LEN_STATUS 4'h2
// parameter byte positions inside a frame
`define RCS_IDX_CRC 5
`define RCS_IDX_IQ 6
// parameter codes
`define RCS_SEL_OFF 8'h00
`define RCS_SEL_ON 8'h01
`define RCS_CAD_CODE_MAX 8'h04
`define RCS_EXIT_STANDBY 8'h00
`define RCS_EXIT_RECEIVE 8'h01
`define RCS_STATUS_UNDEF 8'h00
// register word offsets
`define RCS_REG_CTRL 4'h0
`define RCS_REG_CFG 4'h1
`define RCS_REG_BASE 4'h2
`define RCS_REG_CADTO 4'h3
`define RCS_REG_STAT 4'h4
// control register fields and reset value
`define RCS_CTRL_WDOG_BIT 0
`define RCS_CTRL_MODE_LSB 1
`define RCS_CTRL_REQ_BIT 4
`define RCS_WDOG_EN_RST 1'b1
// timing
`define RCS_CLK_PERIOD_NS 25
`define RCS_CAD_TICK_NS 15625
`define RCS_CAD_TICK_CYC (`RCS_CAD_TICK_NS / `RCS_CLK_PERIOD_NS)
`define RCS_WDOG_US 10000
`define RCS_WDOG_CYC (`RCS_WDOG_US * 1000 / `RCS_CLK_PERIOD_NS)
`endif

// [inc/rcs_pkg.sv]
package rcs_pkg;
   // chip mode field of the status byte
   typedef enum logic [2:0] {
      mode_rc_standby = 3'b010,
      mode_crystal_standby = 3'b011,
      mode_synthesizer = 3'b100,
      mode_receive = 3'b101,
      mode_transmit = 3'b110
   } rcs_mode_t;
   // command status field of the status byte
   typedef enum logic [2:0] {
      cmd_none = 3'b000,
      cmd_data_avail = 3'b010,
      cmd_timeout = 3'b011,
      cmd_proc_err = 3'b100,
      cmd_exec_fail = 3'b101,
      cmd_tx_done = 3'b110
   } rcs_cmd_t;
   typedef struct packed {
      logic rsv_hi;
      rcs_mode_t mode;
      rcs_cmd_t cmd;
      logic rsv_lo;
   } rcs_status_t;
   typedef struct packed {
      logic payload_check_select;
      logic iq_polarity_select;
   } rcs_pkt_cfg_t;
   typedef struct packed {
      logic [7:0] detect_symbol_count_code;
      logic [7:0] detect_peak_threshold;
      logic [7:0] detect_min_threshold;
      logic [7:0] detect_exit_select;
      logic [23:0] detect_rx_timeout;
   } rcs_cad_cfg_t;
endpackage

// [hw/rcs_cmd_decoder.sv]
`timescale 1ns/1ps
`include "rcs_map.svh"
// How it works
// - packet param five: payload check off/on
// - packet param six: standard or inverted IQ
// - opcode 0x88 carries five activity-detect fields
// - symbol code 0..4 gives 1..16 symbols
// - exit code 0: detect, then RC standby
// - exit code 1: on activity, receive until packet or timeout
// - timeout used only for detect-then-receive
// - opcode 0x8F sets tx and rx bases
// - opcode 0xA0 sets validation symbol count
// - count zero: accept on first symbol
// - nonzero count without lock: receive timeout
// - opcode 0xC0: undefined byte, then status
// - status shifts out on every command
// - status byte: mode 6:4, command 3:1
// - packet received reports status 0x2
// - transaction watchdog reports status 0x3
// - bad opcode or length reports 0x4
// - failed execution reports status 0x5
// - transmit finished reports status 0x6
module rcs_cmd_decoder
   import rcs_pkg::*;
#(
   parameter int unsigned WDOG_CYCLES = `RCS_WDOG_CYC
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic spi_sck,
   input wire logic spi_nss_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic pkt_type_ss,
   input wire logic cad_done,
   input wire logic cad_active,
   input wire logic pkt_detect,
   input wire logic symbol_tick,
   input wire logic demod_lock,
   input wire logic rx_done_ok,
   input wire logic tx_done,
   output rcs_pkt_cfg_t pkt_cfg,
   output rcs_cad_cfg_t cad_cfg,
   output logic [4:0] cad_symbols,
   output logic [7:0] tx_base,
   output logic [7:0] rx_base,
   output logic [7:0] validation_symbol_count,
   output rcs_mode_t chip_mode,
   output logic detect_then_receive_active,
   output logic rx_validated,
   output logic receive_timeout_irq
);
   // legal frame length per opcode; unknown opcodes fail
   function automatic logic len_ok(input logic [7:0] op, input logic [3:0] n);
      case (op)
         `RCS_OP_PKT_PARAMS: len_ok = (n >= `RCS_LEN_PKT_MIN) && (n <= `RCS_LEN_PKT_MAX);
         `RCS_OP_CAD_CFG: len_ok = (n == `RCS_LEN_CAD);
         `RCS_OP_BUF_BASE: len_ok = (n == `RCS_LEN_BUF);
         `RCS_OP_SYM_VAL: len_ok = (n == `RCS_LEN_SYM);
         `RCS_OP_STATUS: len_ok = (n == `RCS_LEN_STATUS);
         default: len_ok = 1'b0;
      endcase
   endfunction

   // chip modes that software may request
   function automatic logic mode_legal(input logic [2:0] code);
      mode_legal = (code >= 3'h2) && (code <= 3'h6);
   endfunction

   // pin synchronisers; bit 0 is only read by bit 1
   logic [2:0] sck_sync_ff;
   logic [2:0] nss_sync_ff;
   logic [1:0] mosi_sync_ff;
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         sck_sync_ff <= 3'h0;
         nss_sync_ff <= 3'h7;
         mosi_sync_ff <= 2'h0;
      end else begin
         sck_sync_ff <= {sck_sync_ff[1:0], spi_sck};
         nss_sync_ff <= {nss_sync_ff[1:0], spi_nss_n};
         mosi_sync_ff <= {mosi_sync_ff[0], spi_mosi};
      end
   end

   // edge strobes and the select level in the core domain
   logic sck_rise;
   logic sck_fall;
   logic nss_low;
   logic frame_start;
   logic frame_end;
   assign sck_rise = sck_sync_ff[1] & ~sck_sync_ff[2];
   assign sck_fall = ~sck_sync_ff[1] & sck_sync_ff[2];
   assign nss_low = ~nss_sync_ff[1];
   assign frame_start = ~nss_sync_ff[1] & nss_sync_ff[2];
   assign frame_end = nss_sync_ff[1] & ~nss_sync_ff[2];

   // byte assembly, mode 0, msb first
   logic [2:0] bit_cnt_ff;
   logic [7:0] rx_shift_ff;
   logic [3:0] byte_cnt_ff;
   logic [7:0] opcode_ff;
   logic [7:0] pbuf_ff [1:7];
   logic byte_done;
   logic [7:0] new_byte;
   assign byte_done = sck_rise & nss_low & (bit_cnt_ff == 3'h7);
   assign new_byte = {rx_shift_ff[6:0], mosi_sync_ff[1]};

   // bit position within the current byte
   always_ff @(posedge core_clk) begin
      if (!reset_n || frame_start) begin
         bit_cnt_ff <= 3'h0;
         rx_shift_ff <= 8'h00;
      end else if (sck_rise && nss_low) begin
         bit_cnt_ff <= bit_cnt_ff + 3'h1;
         rx_shift_ff <= new_byte;
      end
   end

   // byte count saturates so long frames still fail length checks
   always_ff @(posedge core_clk) begin
      if (!reset_n || frame_start) begin
         byte_cnt_ff <= 4'h0;
      end else if (byte_done && byte_cnt_ff != 4'hF) begin
         byte_cnt_ff <= byte_cnt_ff + 4'h1;
      end
   end

   // first byte of a frame is the opcode
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         opcode_ff <= 8'h00;
      end else if (byte_done && byte_cnt_ff == 4'h0) begin
         opcode_ff <= new_byte;
      end
   end

   // parameter staging; filler bytes land here and go unused
   for (genvar gi = 1; gi < 8; gi++) begin : g_pbuf
      always_ff @(posedge core_clk) begin
         if (!reset_n) begin
            pbuf_ff[gi] <= 8'h00;
         end else if (byte_done && byte_cnt_ff == 4'(gi)) begin
            pbuf_ff[gi] <= new_byte;
         end
      end
   end

   // transaction watchdog; counts only while selected
   logic [31:0] wdog_cnt_ff;
   logic wdog_en_ff;
   logic wdog_trip_ff;
   logic wdog_fire;
   assign wdog_fire = nss_low & wdog_en_ff & (wdog_cnt_ff == 32'(WDOG_CYCLES - 1));
   always_ff @(posedge core_clk) begin
      if (!reset_n || !nss_low) begin
         wdog_cnt_ff <= 32'h0;
      end else if (wdog_cnt_ff < 32'(WDOG_CYCLES)) begin
         wdog_cnt_ff <= wdog_cnt_ff + 32'h1;
      end
   end
   // a tripped frame is never committed
   always_ff @(posedge core_clk) begin
      if (!reset_n || frame_start) begin
         wdog_trip_ff <= 1'b0;
      end else if (wdog_fire) begin
         wdog_trip_ff <= 1'b1;
      end
   end

   // frame checks at deselect
   logic [7:0] crc_byte;
   logic [7:0] iq_byte;
   logic frame_ok;
   logic params_ok;
   logic commit;
   logic proc_err;
   assign crc_byte = pbuf_ff[`RCS_IDX_CRC];
   assign iq_byte = pbuf_ff[`RCS_IDX_IQ];
   assign frame_ok = len_ok(opcode_ff, byte_cnt_ff) && bit_cnt_ff == 3'h0;
   always_comb begin
      params_ok = 1'b1;
      if (opcode_ff == `RCS_OP_CAD_CFG) begin
         // out-of-range codes are refused, not clamped
         params_ok = (pbuf_ff[1] <= `RCS_CAD_CODE_MAX) && (pbuf_ff[4] <= `RCS_EXIT_RECEIVE);
      end else if (opcode_ff == `RCS_OP_PKT_PARAMS && pkt_type_ss) begin
         params_ok = (crc_byte <= `RCS_SEL_ON) && (iq_byte <= `RCS_SEL_ON);
      end
   end
   assign commit = frame_end & frame_ok & params_ok & ~wdog_trip_ff;
   // empty frames are ignored
   assign proc_err = frame_end & (byte_cnt_ff != 4'h0) & ~wdog_trip_ff
                   & ~(frame_ok & params_ok);

   // packet parameters apply only to the spread-spectrum type
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         pkt_cfg <= '0;
      end else if (commit && opcode_ff == `RCS_OP_PKT_PARAMS && pkt_type_ss) begin
         pkt_cfg.payload_check_select <= (crc_byte == `RCS_SEL_ON);
         pkt_cfg.iq_polarity_select <= (iq_byte == `RCS_SEL_ON);
      end
   end

   // activity-detect setup, bytes in frame order
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         cad_cfg <= '0;
         cad_symbols <= 5'h01;
      end else if (commit && opcode_ff == `RCS_OP_CAD_CFG) begin
         cad_cfg <= {pbuf_ff[1], pbuf_ff[2], pbuf_ff[3], pbuf_ff[4],
                     pbuf_ff[5], pbuf_ff[6], pbuf_ff[7]};
         cad_symbols <= 5'(5'h01 << pbuf_ff[1][2:0]);
      end
   end

   // buffer bases and validation count
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         tx_base <= 8'h00;
         rx_base <= 8'h00;
         validation_symbol_count <= 8'h00;
      end else if (commit && opcode_ff == `RCS_OP_BUF_BASE) begin
         tx_base <= pbuf_ff[1];
         rx_base <= pbuf_ff[2];
      end else if (commit && opcode_ff == `RCS_OP_SYM_VAL) begin
         validation_symbol_count <= pbuf_ff[1];
      end
   end

   // software mode request through the control register
   logic mode_req;
   logic [2:0] mode_code;
   logic exec_fail;
   assign mode_req = reg_wr & (reg_addr == `RCS_REG_CTRL) & reg_wdata[`RCS_CTRL_REQ_BIT];
   assign mode_code = reg_wdata[`RCS_CTRL_MODE_LSB +: 3];
   assign exec_fail = mode_req & ~mode_legal(mode_code);

   // detect-then-receive window timer, in 15.625 us ticks
   logic [9:0] presc_ff;
   logic [23:0] tick_cnt_ff;
   logic presc_wrap;
   logic cad_expire;
   logic cad_to_rx;
   assign presc_wrap = (presc_ff == 10'(`RCS_CAD_TICK_CYC - 1));
   assign cad_to_rx = cad_done & cad_active
                    & (cad_cfg.detect_exit_select == `RCS_EXIT_RECEIVE);
   // the timeout is consulted only in the receive exit
   assign cad_expire = detect_then_receive_active & presc_wrap & ~pkt_detect
                     & (({1'b0, tick_cnt_ff} + 25'h1) >= {1'b0, cad_cfg.detect_rx_timeout});
   always_ff @(posedge core_clk) begin
      if (!reset_n || !detect_then_receive_active || cad_done) begin
         presc_ff <= 10'h0;
         tick_cnt_ff <= 24'h0;
      end else if (presc_wrap) begin
         presc_ff <= 10'h0;
         tick_cnt_ff <= tick_cnt_ff + 24'h1;
      end else begin
         presc_ff <= presc_ff + 10'h1;
      end
   end
   // window ends on packet, expiry or a new mode request
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         detect_then_receive_active <= 1'b0;
      end else if (cad_done) begin
         detect_then_receive_active <= cad_to_rx;
      end else if (pkt_detect || cad_expire || mode_req) begin
         detect_then_receive_active <= 1'b0;
      end
   end

   // chip mode; detection outcomes take priority over software
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         chip_mode <= mode_rc_standby;
      end else if (cad_done) begin
         // standby exit ignores whether activity was seen
         chip_mode <= cad_to_rx ? mode_receive : mode_rc_standby;
      end else if (cad_expire) begin
         chip_mode <= mode_rc_standby;
      end else if (mode_req && mode_legal(mode_code)) begin
         chip_mode <= rcs_mode_t'(mode_code);
      end
   end

   // symbol validation while receiving
   logic [7:0] sym_cnt_ff;
   logic sym_done_ff;
   logic sym_last;
   assign sym_last = (sym_cnt_ff + 8'h1) == validation_symbol_count;
   always_ff @(posedge core_clk) begin
      if (!reset_n || chip_mode != mode_receive) begin
         sym_cnt_ff <= 8'h00;
         sym_done_ff <= 1'b0;
         rx_validated <= 1'b0;
         receive_timeout_irq <= 1'b0;
      end else begin
         rx_validated <= 1'b0;
         receive_timeout_irq <= cad_expire;
         if (symbol_tick && !sym_done_ff) begin
            sym_cnt_ff <= sym_cnt_ff + 8'h1;
            if (validation_symbol_count == 8'h00) begin
               sym_done_ff <= 1'b1;
               rx_validated <= 1'b1;
            end else if (sym_last) begin
               // decision waits for the full count
               sym_done_ff <= 1'b1;
               rx_validated <= demod_lock;
               receive_timeout_irq <= ~demod_lock | cad_expire;
            end
         end
      end
   end

   // command status; a new event beats the clear after read-out
   rcs_cmd_t cmd_ff;
   logic status_sent_ff;
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         cmd_ff <= cmd_none;
      end else if (proc_err) begin
         cmd_ff <= cmd_proc_err;
      end else if (exec_fail) begin
         cmd_ff <= cmd_exec_fail;
      end else if (wdog_fire) begin
         cmd_ff <= cmd_timeout;
      end else if (tx_done) begin
         cmd_ff <= cmd_tx_done;
      end else if (rx_done_ok) begin
         cmd_ff <= cmd_data_avail;
      end else if (frame_end && status_sent_ff) begin
         cmd_ff <= cmd_none;
      end
   end

   // status byte layout, reserved bits zero
   rcs_status_t status_live;
   assign status_live = '{rsv_hi: 1'b0, mode: chip_mode, cmd: cmd_ff, rsv_lo: 1'b0};

   // return path: undefined first byte, status on every later one
   logic [7:0] tx_shift_ff;
   always_ff @(posedge core_clk) begin
      if (!reset_n || frame_start) begin
         tx_shift_ff <= `RCS_STATUS_UNDEF;
      end else if (byte_done) begin
         tx_shift_ff <= status_live;
      end else if (sck_fall && nss_low && bit_cnt_ff != 3'h0) begin
         tx_shift_ff <= {tx_shift_ff[6:0], 1'b0};
      end
   end
   // remembers that a status byte went out in this frame
   always_ff @(posedge core_clk) begin
      if (!reset_n || frame_start) begin
         status_sent_ff <= 1'b0;
      end else if (byte_done) begin
         status_sent_ff <= 1'b1;
      end
   end
   // drive data only while selected
   logic miso_oe_ff;
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         miso_oe_ff <= 1'b0;
      end else begin
         miso_oe_ff <= nss_low;
      end
   end
   assign spi_miso = tx_shift_ff[7];
   assign spi_miso_oe = miso_oe_ff;

   // control register; mode request bit is a write-only trigger
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         wdog_en_ff <= `RCS_WDOG_EN_RST;
      end else if (reg_wr && reg_addr == `RCS_REG_CTRL) begin
         wdog_en_ff <= reg_wdata[`RCS_CTRL_WDOG_BIT];
      end
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge core_clk) begin
      if (!reset_n || !reg_rd) begin
         reg_rdata <= 32'h0;
      end else begin
         case (reg_addr)
            `RCS_REG_CTRL: reg_rdata <= {31'h0, wdog_en_ff};
            `RCS_REG_CFG: reg_rdata <= {8'h0, validation_symbol_count,
                                        cad_cfg.detect_exit_select,
                                        6'h0, pkt_cfg};
            `RCS_REG_BASE: reg_rdata <= {16'h0, rx_base, tx_base};
            `RCS_REG_CADTO: reg_rdata <= {8'h0, cad_cfg.detect_rx_timeout};
            `RCS_REG_STAT: reg_rdata <= {23'h0, detect_then_receive_active, status_live};
            default: reg_rdata <= 32'h0;
         endcase
      end
   end

   // checks
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   sequence s_commit_op(logic [7:0] op);
      commit && opcode_ff == op;
   endsequence
   sequence s_bad_frame;
      frame_end && byte_cnt_ff != 4'h0 && !wdog_trip_ff && !frame_ok;
   endsequence

   a_crc_apply: assert property (
      s_commit_op(`RCS_OP_PKT_PARAMS) and pkt_type_ss
      |=> pkt_cfg.payload_check_select == ($past(crc_byte) == `RCS_SEL_ON))
      else $error("payload check select not applied");
   a_iq_apply: assert property (
      s_commit_op(`RCS_OP_PKT_PARAMS) and pkt_type_ss
      |=> pkt_cfg.iq_polarity_select == ($past(iq_byte) == `RCS_SEL_ON))
      else $error("iq polarity select not applied");
   a_cad_symbols: assert property (
      s_commit_op(`RCS_OP_CAD_CFG) and pbuf_ff[1] == `RCS_CAD_CODE_MAX
      |=> cad_symbols == 5'h10)
      else $error("sixteen symbol code not applied");
   a_exit_standby: assert property (
      cad_done && cad_cfg.detect_exit_select == `RCS_EXIT_STANDBY
      |=> chip_mode == mode_rc_standby && !detect_then_receive_active)
      else $error("detect-only exit did not reach standby");
   a_exit_receive: assert property (
      cad_done && cad_active && cad_cfg.detect_exit_select == `RCS_EXIT_RECEIVE
      |=> chip_mode == mode_receive && detect_then_receive_active)
      else $error("detect-then-receive did not enter receive");
   a_bases_apply: assert property (
      s_commit_op(`RCS_OP_BUF_BASE)
      |=> tx_base == $past(pbuf_ff[1]) && rx_base == $past(pbuf_ff[2]))
      else $error("buffer bases not applied");
   a_valid_zero: assert property (
      chip_mode == mode_receive && validation_symbol_count == 8'h00
      && symbol_tick && !sym_done_ff && !cad_done && !cad_expire && !mode_req
      |=> rx_validated)
      else $error("zero count did not accept on first symbol");
   a_status_shift: assert property (
      byte_done |=> tx_shift_ff == $past(status_live) ##1 spi_miso_oe)
      else $error("status byte not loaded at byte boundary");
   a_len_error: assert property (
      s_bad_frame |=> cmd_ff == cmd_proc_err)
      else $error("bad frame not reported");
   a_wdog_status: assert property (
      wdog_fire && !proc_err && !exec_fail |=> cmd_ff == cmd_timeout)
      else $error("watchdog trip not reported");
endmodule // rcs_cmd_decoder

// [verif/rcs_host_model.sv]
`timescale 1ns/1ps
// host end of the serial link: mode 0, msb first, one frame per call
module rcs_host_model (
   output logic spi_sck,
   output logic spi_nss_n,
   output logic spi_mosi,
   input wire logic spi_miso
);
   logic [7:0] mo [10]; // bytes sent, opcode first
   logic [7:0] mi [10]; // bytes returned
   initial begin
      spi_sck = 1'b0; // clock stands still low between frames
      spi_nss_n = 1'b1;
      spi_mosi = 1'b0;
   end
   // opcode then parameters, thresholds as the bench picks them
   task automatic frame(input int n, input int stall_ns);
      spi_nss_n = 1'b0;
      #(300 + stall_ns); // a long stall trips the device watchdog
      for (int i = 0; i < n; i++) begin
         for (int k = 7; k >= 0; k--) begin
            spi_mosi = mo[i][k];
            #90 mi[i][k] = spi_miso; // late in the bit, after sync lag
            #10 spi_sck = 1'b1;
            #100 spi_sck = 1'b0;
         end
      end
      #200 spi_nss_n = 1'b1;
      spi_mosi = ~spi_mosi; // released line shows no stale value
      #300;
   endtask
endmodule // rcs_host_model

// [verif/radio_cad_status_commands_bench.sv]
`timescale 1ns/1ps
`include "rcs_map.svh"
module radio_cad_status_commands_bench
   import rcs_pkg::*;
;
   logic core_clk, reset_n, spi_sck, spi_nss_n, spi_mosi, spi_miso, spi_miso_oe, miso_w;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, d;
   logic reg_wr, reg_rd, pkt_type_ss, cad_done, cad_active, pkt_detect, symbol_tick;
   logic demod_lock, rx_done_ok, tx_done, detect_then_receive_active, rx_validated, receive_timeout_irq;
   rcs_pkt_cfg_t pkt_cfg;
   rcs_cad_cfg_t cad_cfg;
   rcs_mode_t chip_mode;
   logic [4:0] cad_symbols;
   logic [7:0] tx_base, rx_base, validation_symbol_count, r1, r2, pk, mn;
   logic [23:0] tmo;
   logic [79:0] bad_f [4]; // frames the device must refuse
   int bad_n [4];
   int num_errors, n_tests, n_val, n_irq, seed, i0, cnt;

   // 25 us watchdog: an 8-byte frame fits, a long stall trips it
   rcs_cmd_decoder #(.WDOG_CYCLES(1000)) i_dut (.*);
   rcs_host_model i_host (.spi_sck(spi_sck), .spi_nss_n(spi_nss_n), .spi_mosi(spi_mosi),
      .spi_miso(miso_w));
   assign miso_w = spi_miso_oe ? spi_miso : ~spi_miso; // inverted while released, late enable shows

   always #12.5 core_clk = ~core_clk;
   // count one-cycle pulses from the modem side
   always @(posedge core_clk) begin
      if (rx_validated === 1'b1) n_val++;
      if (receive_timeout_irq === 1'b1) n_irq++;
   end

   task complete_run;
      if (num_errors == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", nm, exp, got);
         num_errors++;
      end
   endtask
   function automatic logic [7:0] sb(input rcs_mode_t m, input rcs_cmd_t c);
      return {1'b0, m, c, 1'b0}; // reserved bits read zero
   endfunction
   task wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task rd(input logic [3:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata; // stands only in this cycle
   endtask
   task spi(input int n, input logic [79:0] v, input int st);
      for (int i = 0; i < n; i++) i_host.mo[i] = v[79-8*i -: 8];
      i_host.frame(n, st);
   endtask
   task pulse(input logic [4:0] p);
      @(posedge core_clk);
      {tx_done, rx_done_ok, symbol_tick, pkt_detect, cad_done} <= p;
      @(posedge core_clk);
      {tx_done, rx_done_ok, symbol_tick, pkt_detect, cad_done} <= 5'h00;
      #1;
   endtask

   initial begin
      core_clk = 1'b0;
      reset_n = 1'b0;
      {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
      {pkt_type_ss, cad_active, demod_lock} = 3'b100;
      {tx_done, rx_done_ok, symbol_tick, pkt_detect, cad_done} = 5'h00;
      seed = 32'h3335;
      bad_f = '{{8'h88, 8'h05, 64'h0}, {8'h55, 72'h0}, {8'h8F, 72'h0},
         {8'h88, 24'h0, 8'h02, 40'h0}};
      bad_n = '{8, 2, 4, 8};
      repeat (12) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      chk("cad_symbols", 1, cad_symbols);
      chk("chip_mode", mode_rc_standby, chip_mode);
      rd(`RCS_REG_CTRL);
      chk("ctrl", 1, d);
      rd(4'hF);
      chk("unmapped", 0, d);
      // buffer bases, status on every byte after the opcode
      r1 = $random(seed);
      r2 = $random(seed);
      spi(3, {`RCS_OP_BUF_BASE, r1, r2, 56'h0}, 0);
      chk("bases", {r2, r1}, {rx_base, tx_base});
      chk("byte0", 0, i_host.mi[0]);
      chk("status", {2{sb(mode_rc_standby, cmd_none)}}, {i_host.mi[1], i_host.mi[2]});
      wr(`RCS_REG_BASE, $random(seed)); // read-only, write dropped
      rd(`RCS_REG_BASE);
      chk("base_reg", {r2, r1}, d[15:0]);
      pk = $random(seed);
      spi(2, {`RCS_OP_SYM_VAL, pk, 64'h0}, 0);
      chk("val_count", pk, validation_symbol_count);
      // packet parameters five and six
      for (int j = 0; j < 4; j++) begin
         spi(7, {8'h8C, 32'h00080010, 7'h0, j[1], 7'h0, j[0], 24'h0}, 0);
         chk("pkt_cfg", j[1:0], pkt_cfg);
      end
      pkt_type_ss <= 1'b0; // other packet type: params not applied
      spi(7, {8'h8C, 32'h00080010, 16'h0000, 24'h0}, 0);
      chk("pkt_cfg", 2'b11, pkt_cfg);
      pkt_type_ss <= 1'b1;
      // every symbol count code
      for (int k = 0; k < 5; k++) begin
         pk = $random(seed);
         mn = $random(seed);
         tmo = $random(seed);
         spi(8, {`RCS_OP_CAD_CFG, k[7:0], pk, mn, 8'h00, tmo, 16'h0}, 0);
         chk("cad_symbols", 5'd1 << k, cad_symbols);
         chk("cad_cfg", {k[7:0], pk, mn, 8'h00, tmo}, cad_cfg);
      end
      rd(`RCS_REG_CADTO);
      chk("cadto", tmo, d[23:0]);
      // refused frames, status read with a random filler byte
      for (int j = 0; j < 4; j++) begin
         spi(bad_n[j], bad_f[j], 0);
         spi(2, {`RCS_OP_STATUS, 8'($random(seed)), 64'h0}, 0);
         chk("refused", sb(mode_rc_standby, cmd_proc_err), i_host.mi[1]);
      end
      chk("cad_symbols", 16, cad_symbols);
      // every chip mode, then a code that cannot be entered
      for (int m = 2; m <= 6; m++) begin
         wr(`RCS_REG_CTRL, {27'h0, 1'b1, m[2:0], 1'b1});
         chk("chip_mode", m[2:0], chip_mode);
      end
      wr(`RCS_REG_CTRL, {27'h0, 1'b1, 3'h7, 1'b1});
      rd(`RCS_REG_STAT);
      chk("stat", sb(mode_transmit, cmd_exec_fail), d[8:0]);
      wr(`RCS_REG_CTRL, {27'h0, 1'b1, 3'h2, 1'b1});
      spi(2, {`RCS_OP_STATUS, 72'h0}, 0);
      // transmit finished, packet received
      for (int j = 0; j < 2; j++) begin
         pulse(j ? 5'h08 : 5'h10);
         rd(`RCS_REG_STAT);
         chk("stat", sb(mode_rc_standby, j ? cmd_data_avail : cmd_tx_done), d[8:0]);
         spi(2, {`RCS_OP_STATUS, 72'h0}, 0);
      end
      // stalled frame trips the watchdog, not applied
      // status is cleared when this frame ends, so look at what it shifted out
      spi(3, {`RCS_OP_BUF_BASE, ~r1, ~r2, 56'h0}, 26000);
      chk("stat", sb(mode_rc_standby, cmd_timeout), i_host.mi[1]);
      chk("bases", {r2, r1}, {rx_base, tx_base});
      // validation count zero, then three symbols without lock
      spi(2, {`RCS_OP_SYM_VAL, 8'h00, 64'h0}, 0);
      wr(`RCS_REG_CTRL, {27'h0, 1'b1, 3'h5, 1'b1});
      demod_lock <= 1'b1;
      i0 = n_val;
      pulse(5'h04);
      repeat (2) @(posedge core_clk);
      chk("validated", 1, n_val - i0);
      spi(2, {`RCS_OP_SYM_VAL, 8'h03, 64'h0}, 0);
      wr(`RCS_REG_CTRL, {27'h0, 1'b1, 3'h2, 1'b1});
      wr(`RCS_REG_CTRL, {27'h0, 1'b1, 3'h5, 1'b1});
      demod_lock <= 1'b0;
      i0 = n_irq;
      repeat (3) pulse(5'h04);
      repeat (2) @(posedge core_clk);
      chk("rx_timeout", 1, n_irq - i0);
      wr(`RCS_REG_CTRL, {27'h0, 1'b1, 3'h2, 1'b1});
      // detect then receive, window of two ticks of 625 cycles
      spi(8, {`RCS_OP_CAD_CFG, 8'h00, pk, mn, 8'h01, 24'd2, 16'h0}, 0);
      cad_active <= 1'b1;
      i0 = n_irq;
      pulse(5'h01);
      chk("rx_mode", {1'b1, mode_receive}, {detect_then_receive_active, chip_mode});
      cnt = 0;
      while (detect_then_receive_active === 1'b1 && cnt < 2000) begin
         @(posedge core_clk);
         #1 cnt++;
      end
      chk("window", 1, cnt >= 1248 && cnt <= 1252);
      repeat (2) @(posedge core_clk);
      chk("rx_end", {1'b1, mode_rc_standby}, {n_irq - i0 == 1, chip_mode});
      // detect only ignores even the largest timeout
      spi(8, {`RCS_OP_CAD_CFG, 8'h00, pk, mn, 8'h00, 24'hFFFFFF, 16'h0}, 0);
      pulse(5'h01);
      chk("standby", {1'b0, mode_rc_standby}, {detect_then_receive_active, chip_mode});
      // packet found closes the window early
      spi(8, {`RCS_OP_CAD_CFG, 8'h00, pk, mn, 8'h01, 24'd100, 16'h0}, 0);
      pulse(5'h01);
      repeat (10) @(posedge core_clk);
      pulse(5'h02);
      chk("rx_closed", 0, detect_then_receive_active);
      complete_run;
   end
   // cut a hang short
   initial begin
      repeat (100000) @(posedge core_clk);
      num_errors++;
      complete_run;
   end
endmodule // radio_cad_status_commands_bench
